//--- svsm_consts.svh
// Purpose: Offsets, fields, reset values and timing counts of the supply monitor
// Assumes: 100 MHz pclk, APB with one 32-bit word per register
// Notes: Byte addresses; bits above a field read as zero
`ifndef SVSM_CONSTS_SVH
`define SVSM_CONSTS_SVH

`define SVSM_ADDR_W 8
`define SVSM_THR_W 6
`define SVSM_TMR_W 17

`define SVSM_OFF_CTRL 8'h00
`define SVSM_OFF_MON_THR 8'h04
`define SVSM_OFF_STATUS 8'h08
`define SVSM_OFF_IRQ_STATUS 8'h0c
`define SVSM_OFF_IRQ_CLEAR 8'h10
`define SVSM_OFF_IRQ_ENABLE 8'h14
`define SVSM_OFF_OTP_VIEW 8'h18

`define SVSM_CTRL_MON_EN_BIT 0
`define SVSM_IRQ_MON_BIT 0
`define SVSM_IRQ_BACKUP_BIT 1
`define SVSM_IRQ_ACTIVE_BIT 2
`define SVSM_IRQ_W 3
`define SVSM_STATUS_STATE_LSB 0
`define SVSM_STATUS_MAIN_BIT 4
`define SVSM_STATUS_LOW_BIT 5
`define SVSM_STATUS_MON_BIT 6
`define SVSM_STATUS_DB_BIT 7
`define SVSM_OTP_LOW_LSB 0
`define SVSM_OTP_START_LSB 8
`define SVSM_OTP_BUF_BIT 16

`define SVSM_RST_CTRL 1'b0
`define SVSM_RST_MON_THR 6'h00
`define SVSM_RST_IRQ 3'h0

`define SVSM_CLK_PERIOD_NS 10
`define SVSM_DEGLITCH_NS 180000
`define SVSM_DEBOUNCE_NS 125000
`define SVSM_SAMPLE_NS 1000000
`define SVSM_DEGLITCH_CYC ((`SVSM_DEGLITCH_NS + `SVSM_CLK_PERIOD_NS - 1) / `SVSM_CLK_PERIOD_NS)
`define SVSM_DEBOUNCE_CYC ((`SVSM_DEBOUNCE_NS + `SVSM_CLK_PERIOD_NS - 1) / `SVSM_CLK_PERIOD_NS)
`define SVSM_SAMPLE_CYC (`SVSM_SAMPLE_NS / `SVSM_CLK_PERIOD_NS)
`define SVSM_STRAP_SETTLE 2'h3

`endif

//--- svsm_monitor.sv
// Purpose: Supply voltage state monitor with APB registers and interrupt
// Assumes: Comparator outputs, straps and requests are asynchronous levels
// Notes: Zero-wait APB slave; read data registered in the setup cycle
`timescale 1ns/1ns
`default_nettype none
`include "svsm_consts.svh"
module svsm_monitor #(
	parameter int unsigned DEGLITCH_CYCLES = `SVSM_DEGLITCH_CYC,
	parameter int unsigned DEBOUNCE_CYCLES = `SVSM_DEBOUNCE_CYC,
	parameter int unsigned SAMPLE_CYCLES = `SVSM_SAMPLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SVSM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic main_supply_pin_above_por,
	input wire logic main_supply_pin_above_low,
	input wire logic runtime_supply_monitor_pass,
	input wire logic [`SVSM_THR_W-1:0] otp_low_supply_threshold,
	input wire logic [`SVSM_THR_W-1:0] otp_startup_supply_threshold,
	input wire logic otp_sense_buffer,
	input wire logic crystal_present,
	input wire logic silicon_continuous_por,
	input wire logic switch_on_req,
	input wire logic sleep_req,
	output logic [2:0] power_state,
	output logic rtc_on,
	output logic always_on_rtc_regulator_en,
	output logic regulators_en,
	output logic [`SVSM_THR_W-1:0] low_supply_threshold,
	output logic [`SVSM_THR_W-1:0] runtime_supply_monitor_threshold,
	output logic runtime_supply_monitor_en,
	output logic sense_buffer_en,
	output logic irq
);
	localparam int SYNC_W = 7;
	localparam int STRAP_W = 2 * `SVSM_THR_W + 1;

	// Synchronised asynchronous inputs
	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_val;
	logic [STRAP_W-1:0] strap_sync;
	logic main_above_por;
	logic main_above_low;
	logic mon_pass;
	logic xtal_s;
	logic cont_por_s;
	logic on_req_s;
	logic sleep_req_s;

	assign sync_raw = {sleep_req, switch_on_req, silicon_continuous_por, crystal_present,
		runtime_supply_monitor_pass, main_supply_pin_above_low, main_supply_pin_above_por};

	svsm_sync #(.W(SYNC_W)) u_sync_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(sync_raw),
		.sync_out(sync_val)
	);

	svsm_sync #(.W(STRAP_W)) u_sync_strap (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({otp_sense_buffer, otp_startup_supply_threshold, otp_low_supply_threshold}),
		.sync_out(strap_sync)
	);

	assign main_above_por = sync_val[0];
	assign main_above_low = sync_val[1];
	assign mon_pass = sync_val[2];
	assign xtal_s = sync_val[3];
	assign cont_por_s = sync_val[4];
	assign on_req_s = sync_val[5];
	assign sleep_req_s = sync_val[6];

	// Straps caught in the first three cycles after reset release, last one kept, never by software
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	logic [`SVSM_THR_W-1:0] otp_low_q;
	logic [`SVSM_THR_W-1:0] otp_low_d;
	logic [`SVSM_THR_W-1:0] otp_start_q;
	logic [`SVSM_THR_W-1:0] otp_start_d;
	logic otp_buf_q;
	logic otp_buf_d;

	always_comb begin
		settle_d = settle_q;
		otp_low_d = otp_low_q;
		otp_start_d = otp_start_q;
		otp_buf_d = otp_buf_q;
		if (settle_q != `SVSM_STRAP_SETTLE) begin
			settle_d = settle_q + 2'h1;
			otp_low_d = strap_sync[`SVSM_THR_W-1:0];
			otp_start_d = strap_sync[2*`SVSM_THR_W-1:`SVSM_THR_W];
			otp_buf_d = strap_sync[STRAP_W-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q <= 2'h0;
			otp_low_q <= '0;
			otp_start_q <= '0;
			otp_buf_q <= 1'b0;
		end else begin
			settle_q <= settle_d;
			otp_low_q <= otp_low_d;
			otp_start_q <= otp_start_d;
			otp_buf_q <= otp_buf_d;
		end
	end

	// Power-on level: loss caught by periodic sample on older silicon, rise taken at once; continuous on newer
	logic smp_busy;
	logic smp_tick;
	logic por_smp_q;
	logic por_smp_d;
	logic main_ok;

	svsm_timer u_sample (
		.pclk(pclk),
		.presetn(presetn),
		.start(!smp_busy),
		.abort(1'b0),
		.load_val(`SVSM_TMR_W'(SAMPLE_CYCLES)),
		.busy(smp_busy),
		.expire(smp_tick)
	);

	always_comb begin
		por_smp_d = por_smp_q;
		if (smp_tick) begin
			por_smp_d = main_above_por;
		end else if (!por_smp_q && main_above_por) begin
			por_smp_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_smp_q <= 1'b0;
		end else begin
			por_smp_q <= por_smp_d;
		end
	end

	assign main_ok = cont_por_s ? main_above_por : por_smp_q;

	// Low-supply deglitch when running without crystal
	svsm_pkg::svsm_state_e state_q;
	svsm_pkg::svsm_state_e state_d;
	logic low_prev_q;
	logic low_fall;
	logic dg_busy;
	logic dg_expire;
	logic running;
	logic low_trip;

	assign running = (state_q == svsm_pkg::ST_ACTIVE) || (state_q == svsm_pkg::ST_SLEEP);
	assign low_fall = low_prev_q && !main_above_low;

	svsm_timer u_deglitch (
		.pclk(pclk),
		.presetn(presetn),
		.start(low_fall && running && !xtal_s),
		.abort(main_above_low),
		.load_val(`SVSM_TMR_W'(DEGLITCH_CYCLES)),
		.busy(dg_busy),
		.expire(dg_expire)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_prev_q <= 1'b0;
		end else begin
			low_prev_q <= main_above_low;
		end
	end

	always_comb begin
		if (xtal_s) begin
			low_trip = !main_above_low;
		end else begin
			low_trip = dg_expire && !main_above_low;
		end
	end

	// Power state machine
	logic mon_en_q;
	logic startup;

	assign startup = (state_q == svsm_pkg::ST_OFF) && on_req_s && main_above_low;

	always_comb begin
		state_d = state_q;
		if (!main_ok) begin
			state_d = svsm_pkg::ST_UNPOWERED;
		end else begin
			unique case (state_q)
				svsm_pkg::ST_UNPOWERED: begin
					state_d = svsm_pkg::ST_BACKUP;
				end
				svsm_pkg::ST_BACKUP: begin
					if (main_above_low) begin
						state_d = svsm_pkg::ST_OFF;
					end
				end
				svsm_pkg::ST_OFF: begin
					if (!main_above_low) begin
						state_d = svsm_pkg::ST_BACKUP;
					end else if (startup && mon_pass) begin
						state_d = svsm_pkg::ST_ACTIVE;
					end
				end
				svsm_pkg::ST_ACTIVE: begin
					if (low_trip) begin
						state_d = svsm_pkg::ST_BACKUP;
					end else if (sleep_req_s) begin
						state_d = svsm_pkg::ST_SLEEP;
					end
				end
				svsm_pkg::ST_SLEEP: begin
					if (low_trip) begin
						state_d = svsm_pkg::ST_BACKUP;
					end else if (!sleep_req_s) begin
						state_d = svsm_pkg::ST_ACTIVE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= svsm_pkg::ST_UNPOWERED;
		end else begin
			state_q <= state_d;
		end
	end

	// APB decode
	logic setup;
	logic wr_acc;
	logic hit;
	logic [31:0] rd_mux;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [`SVSM_THR_W-1:0] mon_thr_q;
	logic [`SVSM_THR_W-1:0] mon_thr_d;
	logic mon_en_d;
	logic [`SVSM_IRQ_W-1:0] irq_stat_q;
	logic [`SVSM_IRQ_W-1:0] irq_stat_d;
	logic [`SVSM_IRQ_W-1:0] irq_en_q;
	logic [`SVSM_IRQ_W-1:0] irq_en_d;
	logic [`SVSM_IRQ_W-1:0] irq_set;
	logic db_busy;

	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;

	function automatic logic wr_to(input logic [`SVSM_ADDR_W-1:0] off);
		wr_to = wr_acc && (paddr == off);
	endfunction

	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`SVSM_OFF_CTRL: rd_mux[`SVSM_CTRL_MON_EN_BIT] = mon_en_q;
			`SVSM_OFF_MON_THR: rd_mux[`SVSM_THR_W-1:0] = mon_thr_q;
			`SVSM_OFF_STATUS: begin
				rd_mux[`SVSM_STATUS_STATE_LSB+:3] = state_q;
				rd_mux[`SVSM_STATUS_MAIN_BIT] = main_ok;
				rd_mux[`SVSM_STATUS_LOW_BIT] = main_above_low;
				rd_mux[`SVSM_STATUS_MON_BIT] = mon_pass;
				rd_mux[`SVSM_STATUS_DB_BIT] = db_busy;
			end
			`SVSM_OFF_IRQ_STATUS: rd_mux[`SVSM_IRQ_W-1:0] = irq_stat_q;
			`SVSM_OFF_IRQ_CLEAR: rd_mux = 32'h0000_0000;
			`SVSM_OFF_IRQ_ENABLE: rd_mux[`SVSM_IRQ_W-1:0] = irq_en_q;
			`SVSM_OFF_OTP_VIEW: begin
				rd_mux[`SVSM_OTP_LOW_LSB+:`SVSM_THR_W] = otp_low_q;
				rd_mux[`SVSM_OTP_START_LSB+:`SVSM_THR_W] = otp_start_q;
				rd_mux[`SVSM_OTP_BUF_BIT] = otp_buf_q;
			end
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (setup) begin
			prdata_d = pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_d = !hit;
		end
	end

	// Software-visible control; strap view is read-only
	always_comb begin
		mon_thr_d = mon_thr_q;
		mon_en_d = mon_en_q;
		irq_en_d = irq_en_q;
		if (state_q == svsm_pkg::ST_OFF && state_d == svsm_pkg::ST_ACTIVE) begin
			mon_en_d = 1'b0;
		end
		if (wr_to(`SVSM_OFF_MON_THR)) begin
			mon_thr_d = pwdata[`SVSM_THR_W-1:0];
		end
		if (wr_to(`SVSM_OFF_CTRL)) begin
			mon_en_d = pwdata[`SVSM_CTRL_MON_EN_BIT];
		end
		if (wr_to(`SVSM_OFF_IRQ_ENABLE)) begin
			irq_en_d = pwdata[`SVSM_IRQ_W-1:0];
		end
	end

	// Monitor events with debounce; no hysteresis means edges may repeat
	logic mon_prev_q;
	logic mon_edge;
	logic mon_event;

	assign mon_edge = mon_en_q && running && (mon_prev_q != mon_pass);
	assign mon_event = mon_edge && !db_busy;

	svsm_timer u_debounce (
		.pclk(pclk),
		.presetn(presetn),
		.start(mon_event),
		.abort(1'b0),
		.load_val(`SVSM_TMR_W'(DEBOUNCE_CYCLES)),
		.busy(db_busy),
		.expire()
	);

	always_comb begin
		irq_set = '0;
		irq_set[`SVSM_IRQ_MON_BIT] = mon_event;
		irq_set[`SVSM_IRQ_BACKUP_BIT] = running && (state_d == svsm_pkg::ST_BACKUP);
		irq_set[`SVSM_IRQ_ACTIVE_BIT] = startup && (state_d == svsm_pkg::ST_ACTIVE);
		irq_stat_d = irq_stat_q;
		if (wr_to(`SVSM_OFF_IRQ_CLEAR)) begin
			irq_stat_d = irq_stat_d & ~pwdata[`SVSM_IRQ_W-1:0];
		end
		irq_stat_d = irq_stat_d | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			mon_thr_q <= `SVSM_RST_MON_THR;
			mon_en_q <= `SVSM_RST_CTRL;
			irq_en_q <= `SVSM_RST_IRQ;
			irq_stat_q <= `SVSM_RST_IRQ;
			mon_prev_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			mon_thr_q <= mon_thr_d;
			mon_en_q <= mon_en_d;
			irq_en_q <= irq_en_d;
			irq_stat_q <= irq_stat_d;
			mon_prev_q <= mon_pass;
		end
	end

	// Outputs
	logic [2:0] state_out_q;
	logic regs_q;
	logic rtc_q;
	logic mon_cmp_en_q;
	logic [`SVSM_THR_W-1:0] mon_thr_out_q;
	logic irq_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_out_q <= 3'h0;
			regs_q <= 1'b0;
			rtc_q <= 1'b0;
			mon_cmp_en_q <= 1'b0;
			mon_thr_out_q <= '0;
			irq_q <= 1'b0;
		end else begin
			state_out_q <= state_d;
			regs_q <= (state_d == svsm_pkg::ST_ACTIVE) || (state_d == svsm_pkg::ST_SLEEP);
			rtc_q <= (state_d != svsm_pkg::ST_UNPOWERED);
			mon_cmp_en_q <= (startup && state_d == svsm_pkg::ST_OFF) || mon_en_d;
			mon_thr_out_q <= (state_d == svsm_pkg::ST_OFF) ? otp_start_q : mon_thr_d;
			irq_q <= |(irq_stat_d & irq_en_d);
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = pslverr_q && psel && penable;
	assign power_state = state_out_q;
	assign regulators_en = regs_q;
	assign rtc_on = rtc_q;
	assign always_on_rtc_regulator_en = rtc_q;
	assign low_supply_threshold = otp_low_q;
	assign runtime_supply_monitor_threshold = mon_thr_out_q;
	assign runtime_supply_monitor_en = mon_cmp_en_q;
	assign sense_buffer_en = otp_buf_q && rtc_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

//--- svsm_monitor_props.sv
// Purpose: Port-level properties of the supply monitor
// Assumes: Single pclk domain, comparators asynchronous
// Notes: Margins cover the two-flop input synchronisers
`timescale 1ns/1ns
`default_nettype none
module svsm_monitor_props #(
	parameter int unsigned DEGLITCH_CYCLES = 20,
	parameter int unsigned SAMPLE_CYCLES = 30
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic main_supply_pin_above_por,
	input wire logic main_supply_pin_above_low,
	input wire logic runtime_supply_monitor_pass,
	input wire logic crystal_present,
	input wire logic silicon_continuous_por,
	input wire logic [2:0] power_state,
	input wire logic rtc_on,
	input wire logic always_on_rtc_regulator_en,
	input wire logic regulators_en,
	input wire logic runtime_supply_monitor_en,
	input wire logic irq
);
	localparam logic [2:0] st_un = svsm_pkg::ST_UNPOWERED;
	localparam logic [2:0] st_bk = svsm_pkg::ST_BACKUP;
	localparam logic [2:0] st_of = svsm_pkg::ST_OFF;
	localparam logic [2:0] st_ac = svsm_pkg::ST_ACTIVE;
	int unsigned low_cnt_q, low_cnt_d, por_cnt_q, por_cnt_d;
	always_comb begin
		low_cnt_d = main_supply_pin_above_low ? 0 : low_cnt_q + 1;
		por_cnt_d = main_supply_pin_above_por ? 0 : por_cnt_q + 1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_q <= 0;
			por_cnt_q <= 0;
		end else begin
			low_cnt_q <= low_cnt_d;
			por_cnt_q <= por_cnt_d;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_unp_off;
		power_state == st_un |-> !rtc_on && !always_on_rtc_regulator_en && !regulators_en;
	endproperty
	a_unp_off: assert property (p_unp_off) else $error("unpowered with outputs on");
	property p_por_up;
		main_supply_pin_above_por [*8] |-> power_state != st_un;
	endproperty
	a_por_up: assert property (p_por_up) else $error("no exit from unpowered");
	property p_supply_up;
		(main_supply_pin_above_por && main_supply_pin_above_low) [*8] |-> power_state > st_bk;
	endproperty
	a_supply_up: assert property (p_supply_up) else $error("stuck below off");
	property p_low_xtal;
		crystal_present && low_cnt_q >= 5 |-> !regulators_en;
	endproperty
	a_low_xtal: assert property (p_low_xtal) else $error("regulators late");
	property p_deglitch;
		$fell(regulators_en) && !crystal_present && power_state == st_bk
			|-> low_cnt_q >= DEGLITCH_CYCLES;
	endproperty
	a_deglitch: assert property (p_deglitch) else $error("regulators dropped early");
	property p_backup_regs;
		power_state == st_bk |-> !regulators_en && always_on_rtc_regulator_en;
	endproperty
	a_backup_regs: assert property (p_backup_regs) else $error("backup regulators");
	property p_startup;
		!runtime_supply_monitor_pass [*6] ##0 power_state == st_of |=> power_state != st_ac;
	endproperty
	a_startup: assert property (p_startup) else $error("start without pass");
	property p_mon_off;
		power_state == st_ac && $past(power_state) == st_of |-> ##[0:2] !runtime_supply_monitor_en;
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor left on");
	property p_por_old;
		por_cnt_q >= SAMPLE_CYCLES + 8 |-> power_state == st_un;
	endproperty
	a_por_old: assert property (p_por_old) else $error("sampled loss missed");
	property p_por_new;
		silicon_continuous_por && por_cnt_q >= 6 |-> power_state == st_un;
	endproperty
	a_por_new: assert property (p_por_new) else $error("supply loss missed");
	c_drop: cover property (power_state == st_ac ##1 power_state == st_bk);
	c_irq: cover property ($rose(irq));
	c_loss: cover property ($fell(rtc_on));
endmodule
bind svsm_monitor svsm_monitor_props #(
	.DEGLITCH_CYCLES(DEGLITCH_CYCLES),
	.SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_props (
	.pclk, .presetn, .main_supply_pin_above_por, .main_supply_pin_above_low,
	.runtime_supply_monitor_pass, .crystal_present, .silicon_continuous_por, .power_state,
	.rtc_on, .always_on_rtc_regulator_en, .regulators_en, .runtime_supply_monitor_en, .irq
);
`default_nettype wire

//--- svsm_monitor_tb.sv
// Purpose: Self-checking bench for the supply monitor
// Assumes: Comparators come from svsm_supply_model
// Notes: Short deglitch, debounce and sample counts
`timescale 1ns/1ns
`default_nettype none
`include "svsm_consts.svh"
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("Error %s expected %h seen %h", n, e, g); \
	end \
end
module svsm_monitor_tb;
	localparam int dg = 20;
	localparam int db = 40;
	localparam int sp = 30;
	localparam logic [5:0] thr_lo = 6'h1e;
	localparam logic [5:0] thr_hi = 6'h28;
	localparam logic [31:0] view = {15'h0, 1'b1, 2'h0, thr_hi, 2'h0, thr_lo};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic xtal = 1'b1;
	logic cont = 1'b1;
	logic son = 1'b0;
	logic slp = 1'b0;
	logic [15:0] main_mv = 16'h0;
	logic [15:0] sense_mv = 16'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, por, low, pass, mon_en, rtc, rtc_reg, regs, sbuf_en, irq;
	logic [2:0] ps;
	logic [5:0] lthr, mthr;
	int err_total = 0;
	int total_checks = 0;
	always #5 pclk = ~pclk;
	svsm_monitor #(.DEGLITCH_CYCLES(dg), .DEBOUNCE_CYCLES(db), .SAMPLE_CYCLES(sp)) DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.main_supply_pin_above_por(por), .main_supply_pin_above_low(low),
		.runtime_supply_monitor_pass(pass), .otp_low_supply_threshold(thr_lo),
		.otp_startup_supply_threshold(thr_hi), .otp_sense_buffer(1'b1), .crystal_present(xtal),
		.silicon_continuous_por(cont), .switch_on_req(son), .sleep_req(slp), .power_state(ps),
		.rtc_on(rtc), .always_on_rtc_regulator_en(rtc_reg), .regulators_en(regs),
		.low_supply_threshold(lthr), .runtime_supply_monitor_threshold(mthr),
		.runtime_supply_monitor_en(mon_en), .sense_buffer_en(sbuf_en), .irq
	);
	svsm_supply_model MDL (
		.main_mv, .sense_mv, .low_thr(lthr), .mon_thr(mthr), .mon_en,
		.above_por(por), .above_low(low), .mon_pass(pass)
	);
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic se);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer and error taken at the completing edge only
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK("pready", 1'b1, pready)
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic se;
		apb(1'b0, a, 32'h0, q, se);
		`CHK(nm, x, q)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic se;
		apb(1'b1, a, d, q, se);
	endtask
	task automatic wait_ps(input string nm, input logic [2:0] s, input int lim);
		int n;
		n = 0;
		while (ps !== s && n < lim) begin
			@(posedge pclk);
			n++;
		end
		`CHK(nm, s, ps)
	endtask
	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		$display("Error watchdog expected finish seen hang");
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		wait_ps("unpowered", svsm_pkg::ST_UNPOWERED, 0);
		`CHK("rtc", 1'b0, rtc)
		rdc("ctrl", `SVSM_OFF_CTRL, 32'h0);
		rdc("mon_thr", `SVSM_OFF_MON_THR, 32'h0);
		rdc("irq_en", `SVSM_OFF_IRQ_ENABLE, 32'h0);
		wr(`SVSM_OFF_OTP_VIEW, 32'h0);
		rdc("otp", `SVSM_OFF_OTP_VIEW, view);
		`CHK("low_thr", thr_lo, lthr)
		apb(1'b0, 8'h40, 32'h0, r, e);
		`CHK("slverr", 1'b1, e)
		$display("Test registers done");
		main_mv <= 16'h09c4;
		wait_ps("backup", svsm_pkg::ST_BACKUP, 10);
		`CHK("sense_buf", 1'b1, sbuf_en)
		main_mv <= 16'h0dac;
		wait_ps("off", svsm_pkg::ST_OFF, 10);
		wr(`SVSM_OFF_IRQ_ENABLE, 32'h7);
		wr(`SVSM_OFF_CTRL, 32'h1);
		sense_mv <= 16'h0bb8;
		son <= 1'b1;
		repeat (10) @(posedge pclk);
		wait_ps("gated", svsm_pkg::ST_OFF, 0);
		`CHK("start_thr", thr_hi, mthr)
		sense_mv <= 16'h1194;
		wait_ps("active", svsm_pkg::ST_ACTIVE, 10);
		rdc("ctrl_auto", `SVSM_OFF_CTRL, 32'h0);
		`CHK("mon_off", 1'b0, mon_en)
		rdc("irq_act", `SVSM_OFF_IRQ_STATUS, 32'h4);
		`CHK("irq", 1'b1, irq)
		wr(`SVSM_OFF_IRQ_CLEAR, 32'h7);
		rdc("irq_clr", `SVSM_OFF_IRQ_STATUS, 32'h0);
		`CHK("irq_low", 1'b0, irq)
		$display("Test power-up done");
		wr(`SVSM_OFF_MON_THR, 32'h0a);
		wr(`SVSM_OFF_CTRL, 32'h1);
		repeat (db + 10) @(posedge pclk);
		wr(`SVSM_OFF_IRQ_CLEAR, 32'h7);
		sense_mv <= 16'h0384;
		repeat (6) @(posedge pclk);
		rdc("mon_irq", `SVSM_OFF_IRQ_STATUS, 32'h1);
		wr(`SVSM_OFF_IRQ_CLEAR, 32'h1);
		sense_mv <= 16'h044c;
		repeat (8) @(posedge pclk);
		rdc("debounce", `SVSM_OFF_IRQ_STATUS, 32'h0);
		repeat (db) @(posedge pclk);
		sense_mv <= 16'h0384;
		repeat (6) @(posedge pclk);
		rdc("rearm", `SVSM_OFF_IRQ_STATUS, 32'h1);
		wr(`SVSM_OFF_CTRL, 32'h0);
		$display("Test monitor done");
		slp <= 1'b1;
		wait_ps("sleep", svsm_pkg::ST_SLEEP, 10);
		wr(`SVSM_OFF_IRQ_CLEAR, 32'h7);
		main_mv <= 16'h0af0;
		wait_ps("xtal_drop", svsm_pkg::ST_BACKUP, 6);
		`CHK("regs_off", 1'b0, regs)
		`CHK("rtc_keep", 1'b1, rtc_reg)
		rdc("irq_bk", `SVSM_OFF_IRQ_STATUS, 32'h2);
		slp <= 1'b0;
		xtal <= 1'b0;
		sense_mv <= 16'h1194;
		main_mv <= 16'h0dac;
		wait_ps("active2", svsm_pkg::ST_ACTIVE, 20);
		main_mv <= 16'h0af0;
		repeat (dg / 2) @(posedge pclk);
		main_mv <= 16'h0dac;
		repeat (dg + 5) @(posedge pclk);
		wait_ps("glitch", svsm_pkg::ST_ACTIVE, 0);
		main_mv <= 16'h0af0;
		repeat (dg - 2) @(posedge pclk);
		`CHK("deglitch", 1'b1, regs)
		wait_ps("slow_drop", svsm_pkg::ST_BACKUP, 10);
		`CHK("regs_off2", 1'b0, regs)
		$display("Test undervoltage done");
		son <= 1'b0;
		main_mv <= 16'h0;
		wait_ps("por_new", svsm_pkg::ST_UNPOWERED, 6);
		`CHK("rtc_off", 1'b0, rtc)
		cont <= 1'b0;
		main_mv <= 16'h0dac;
		wait_ps("off3", svsm_pkg::ST_OFF, 10);
		main_mv <= 16'h0;
		wait_ps("por_old", svsm_pkg::ST_UNPOWERED, sp + 8);
		$display("Test power-on reset done");
		print_verdict();
	end
endmodule
`default_nettype wire

//--- svsm_pkg.sv
// Purpose: Types shared by the supply monitor files
// Assumes: Constants live in svsm_consts.svh
// Notes: Power states are encoded in order, ST_UNPOWERED = 0 up to ST_SLEEP = 4
package svsm_pkg;
	typedef enum logic [2:0] {
		ST_UNPOWERED,
		ST_BACKUP,
		ST_OFF,
		ST_ACTIVE,
		ST_SLEEP
	} svsm_state_e;
endpackage

//--- svsm_supply_model.sv
// Purpose: Behavioural supply comparators facing the monitor
// Assumes: Voltages in millivolts, thresholds in 100 mV steps
// Notes: A disabled monitor comparator reads low
`timescale 1ns/1ns
`default_nettype none
module svsm_supply_model #(
	parameter logic [15:0] POR_MV = 16'h07d0
) (
	input wire logic [15:0] main_mv,
	input wire logic [15:0] sense_mv,
	input wire logic [5:0] low_thr,
	input wire logic [5:0] mon_thr,
	input wire logic mon_en,
	output logic above_por,
	output logic above_low,
	output logic mon_pass
);
	assign above_por = main_mv >= POR_MV;
	// Level taken from the strap copy only
	assign above_low = main_mv >= {10'h0, low_thr} * 16'h0064;
	// Same level both ways
	assign mon_pass = mon_en && (sense_mv >= {10'h0, mon_thr} * 16'h0064);
endmodule
`default_nettype wire

//--- svsm_sync.sv
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Inputs are levels, held for several pclk periods
// Notes: First stage feeds the second stage only
`timescale 1ns/1ns
`default_nettype none
module svsm_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] stab_q;
	logic [W-1:0] stab_d;

	always_comb begin
		meta_d = async_in;
		stab_d = meta_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			stab_q <= '0;
		end else begin
			meta_q <= meta_d;
			stab_q <= stab_d;
		end
	end

	assign sync_out = stab_q;
endmodule
`default_nettype wire

//--- svsm_timer.sv
// Purpose: Loadable down-counter giving a one-cycle expiry pulse
// Assumes: Load value at least 1
// Notes: Load wins over abort; expire fires on the last counted cycle
`timescale 1ns/1ns
`default_nettype none
`include "svsm_consts.svh"
module svsm_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic abort,
	input wire logic [`SVSM_TMR_W-1:0] load_val,
	output logic busy,
	output logic expire
);
	logic [`SVSM_TMR_W-1:0] cnt_q;
	logic [`SVSM_TMR_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (start) begin
			cnt_d = load_val;
		end else if (abort) begin
			cnt_d = '0;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - `SVSM_TMR_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy = (cnt_q != '0);
	assign expire = (cnt_q == `SVSM_TMR_W'(1)) && !start && !abort;
endmodule
`default_nettype wire
